// file: common/usu_pkg.sv
// package of constants and types for the usb serial uart line option block
package usu_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int REF_HZ = 3_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int WAKE_MS = 20;
  localparam int WAKE_CYCLES = WAKE_MS * MS_CYCLES;
  localparam int ACT_PULSE_CYCLES = 4096;
  localparam int CLKOUT_STEP = 96;
  localparam int CLKOUT_MOD = 100;
  // ==========================================================
  // divisor
  localparam int DIV_INT_W = 14;
  localparam int DIV_FRAC_W = 3;
  localparam logic [DIV_INT_W-1:0] DIV_INT_RST = 14'h2710;
  localparam logic [DIV_INT_W:0] DIV_INT_MAX = 15'h4000;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_RXTO = 8'h08;
  localparam logic [7:0] ADDR_INVERT = 8'h0c;
  localparam logic [7:0] ADDR_CONFIGURABLE_IO_LINES_FUNC = 8'h10;
  localparam logic [7:0] ADDR_CONFIGURABLE_IO_LINES_GPIO = 8'h14;
  localparam logic [7:0] ADDR_TXDATA = 8'h18;
  localparam logic [7:0] ADDR_RXDATA = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_BB_DIR = 8'h24;
  localparam logic [7:0] ADDR_BB_IN = 8'h28;
  localparam logic [7:0] ADDR_CHIP_ID = 8'h2c;
  // ==========================================================
  // field positions and reset values
  localparam int BAUD_FRAC_LSB = 14;
  localparam int RXDATA_VALID_BIT = 8;
  localparam int ST_TX_BUSY = 0;
  localparam int ST_RX_VALID = 1;
  localparam int ST_FLUSH = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_MODEM_LSB = 4;
  localparam int ST_CONFIGURABLE_IO_LINES_LSB = 8;
  localparam int ST_WAKE = 12;
  localparam logic [7:0] RXTO_RST = 8'h10;
  localparam logic [7:0] RXTO_MIN = 8'h01;
  localparam logic [15:0] CONFIGURABLE_IO_LINES_FUNC_RST = 16'h5210;
  // bit positions of the eight uart lines, shared with bit-bang byte order
  localparam int LN_TXD = 0;
  localparam int LN_RXD = 1;
  localparam int LN_RTS = 2;
  localparam int LN_CTS = 3;
  localparam int LN_DTR = 4;
  localparam int LN_DSR = 5;
  localparam int LN_DCD = 6;
  localparam int LN_RI = 7;
  localparam logic [7:0] UART_OUT_MASK = 8'h15;
  localparam int NUM_CONFIGURABLE_IO_LINES = 4;
  // ==========================================================
  // types
  typedef enum logic [3:0] {
    CB_TX_DRIVER_ENABLE, CB_POWER_SWITCH_ENABLE, CB_TX_ACT, CB_RX_ACT, CB_TXRX_ACT,
    CB_SUSPEND, CB_CLOCK_OUT_48M, CB_CLOCK_OUT_24M, CB_CLOCK_OUT_12M, CB_CLOCK_OUT_6M, CB_GPIO
  } usu_configurable_io_lines_func_t;

  typedef struct packed {
    logic rts;
    logic dtr;
    logic wake_en;
    logic bleed_en;
    logic configurable_io_lines_bitbang_en;
    logic bitbang_en;
  } usu_ctrl_t;

  localparam usu_ctrl_t CTRL_RST = '{default: 1'b0};
endpackage

// file: rtl/usu_baud_gen.sv
// fractional bit-rate tick generator from a 3 MHz reference
`timescale 1ns/1ps
`default_nettype none
module usu_baud_gen
  import usu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic half,
  input wire logic [DIV_INT_W-1:0] div_int,
  input wire logic [DIV_FRAC_W-1:0] div_frac,
  output logic tick
);
  // ==========================================================
  // 3 mhz reference from the system clock
  localparam logic [6:0] REF_STEP = 7'(REF_HZ / 1_000_000);
  localparam logic [6:0] REF_MOD = 7'(CLK_HZ / 1_000_000);
  logic [6:0] ref_acc_ff;
  logic ref_tick;
  logic [6:0] ref_sum;

  assign ref_sum = ref_acc_ff + REF_STEP;
  assign ref_tick = (ref_sum >= REF_MOD);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_acc_ff <= 7'h00;
    end else if (restart) begin
      ref_acc_ff <= 7'h00;
    end else if (ref_tick) begin
      ref_acc_ff <= ref_sum - REF_MOD;
    end else begin
      ref_acc_ff <= ref_sum;
    end
  end

  // ==========================================================
  // divisor in eighths of a reference period
  logic [DIV_INT_W:0] n_eff;
  logic [DIV_FRAC_W-1:0] x_eff;
  logic [18:0] div8;
  logic [18:0] acc_ff;
  logic [18:0] acc_sum;

  // a zero integer field stands for 16384, the top of the range
  assign n_eff = (div_int == '0) ? DIV_INT_MAX : {1'b0, div_int};
  // fractions are dropped at divisor 1 and at the 16384 limit
  assign x_eff = (n_eff == 15'h0001 || n_eff == DIV_INT_MAX) ? '0 : div_frac;
  assign div8 = {1'b0, n_eff, 3'h0} + {16'h0000, x_eff};
  assign acc_sum = acc_ff + 19'h00008;

  // the remainder carries into the next bit, so bit lengths alternate
  // between n and n+1 reference periods and average to n + x/8
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= 19'h00000;
      tick <= 1'b0;
    end else if (restart) begin
      acc_ff <= half ? (div8 >> 1) : 19'h00000;
      tick <= 1'b0;
    end else if (ref_tick && acc_sum >= div8) begin
      acc_ff <= acc_sum - div8;
      tick <= 1'b1;
    end else begin
      acc_ff <= ref_tick ? acc_sum : acc_ff;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: rtl/usu_uart_top.sv
// uart line side of a usb serial bridge with apb register access
`timescale 1ns/1ps
`default_nettype none
module usu_uart_top
  import usu_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES,
  parameter int WAKE_CYC = WAKE_CYCLES,
  parameter logic [31:0] CHIP_ID = 32'h5a3c_0001 // arbitrary value
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] uart_line_in,
  output logic [7:0] uart_line_out,
  output logic [7:0] uart_line_oe_n,
  output logic uart_bleed_pulldown,
  input wire logic [NUM_CONFIGURABLE_IO_LINES-1:0] configurable_io_lines_in,
  output logic [NUM_CONFIGURABLE_IO_LINES-1:0] configurable_io_lines_out,
  output logic [NUM_CONFIGURABLE_IO_LINES-1:0] configurable_io_lines_oe_n,
  input wire logic usb_configured,
  input wire logic usb_suspend,
  output logic usb_resume_req,
  output logic rx_flush,
  output logic power_switch_enable_n
);
  // ==========================================================
  // external reset and pin synchronisers
  logic [1:0] ext_rst_sync_ff;
  logic soft_rst;
  logic [7:0] line_meta_ff;
  logic [7:0] line_sync_ff;
  logic [NUM_CONFIGURABLE_IO_LINES-1:0] configurable_io_lines_meta_ff;
  logic [NUM_CONFIGURABLE_IO_LINES-1:0] configurable_io_lines_sync_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_rst_sync_ff <= 2'h3;
    end else begin
      ext_rst_sync_ff <= {ext_rst_sync_ff[0], ext_reset_n};
    end
  end
  assign soft_rst = !ext_rst_sync_ff[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_meta_ff <= 8'hff;
      line_sync_ff <= 8'hff;
      configurable_io_lines_meta_ff <= '0;
      configurable_io_lines_sync_ff <= '0;
    end else begin
      line_meta_ff <= uart_line_in;
      line_sync_ff <= line_meta_ff;
      configurable_io_lines_meta_ff <= configurable_io_lines_in;
      configurable_io_lines_sync_ff <= configurable_io_lines_meta_ff;
    end
  end

  // ==========================================================
  // register file
  usu_ctrl_t ctrl_ff;
  logic [DIV_INT_W-1:0] div_int_ff;
  logic [DIV_FRAC_W-1:0] div_frac_ff;
  logic [7:0] rxto_ff;
  logic [7:0] invert_ff;
  logic [15:0] configurable_io_lines_func_ff;
  logic [NUM_CONFIGURABLE_IO_LINES-1:0] gpio_out_ff;
  logic [NUM_CONFIGURABLE_IO_LINES-1:0] gpio_dir_ff;
  logic [7:0] bb_dir_ff;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic tx_busy_ff;
  logic [7:0] rx_data_ff;
  logic rx_valid_ff;
  logic flush_ff;
  logic overrun_ff;
  logic wake_ff;
  logic [7:0] line_log;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;

  always_comb begin
    unique case (paddr)
      ADDR_CTRL, ADDR_BAUD, ADDR_RXTO, ADDR_INVERT, ADDR_CONFIGURABLE_IO_LINES_FUNC, ADDR_CONFIGURABLE_IO_LINES_GPIO,
      ADDR_TXDATA, ADDR_RXDATA, ADDR_STATUS, ADDR_BB_DIR, ADDR_BB_IN, ADDR_CHIP_ID: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RST;
      div_int_ff <= DIV_INT_RST;
      div_frac_ff <= '0;
      rxto_ff <= RXTO_RST;
      invert_ff <= 8'h00;
      configurable_io_lines_func_ff <= CONFIGURABLE_IO_LINES_FUNC_RST;
      gpio_out_ff <= '0;
      gpio_dir_ff <= '0;
      bb_dir_ff <= 8'h00;
    end else if (soft_rst) begin
      ctrl_ff <= CTRL_RST;
      div_int_ff <= DIV_INT_RST;
      div_frac_ff <= '0;
      rxto_ff <= RXTO_RST;
      invert_ff <= 8'h00;
      configurable_io_lines_func_ff <= CONFIGURABLE_IO_LINES_FUNC_RST;
      gpio_out_ff <= '0;
      gpio_dir_ff <= '0;
      bb_dir_ff <= 8'h00;
    end else if (wr_en) begin
      unique case (paddr)
        ADDR_CTRL: ctrl_ff <= usu_ctrl_t'(pwdata[5:0]);
        ADDR_BAUD: begin
          div_int_ff <= pwdata[DIV_INT_W-1:0];
          div_frac_ff <= pwdata[BAUD_FRAC_LSB +: DIV_FRAC_W];
        end
        // zero is out of range and is taken as the shortest timeout
        ADDR_RXTO: rxto_ff <= (pwdata[7:0] == 8'h00) ? RXTO_MIN : pwdata[7:0];
        ADDR_INVERT: invert_ff <= pwdata[7:0];
        ADDR_CONFIGURABLE_IO_LINES_FUNC: configurable_io_lines_func_ff <= pwdata[15:0];
        ADDR_CONFIGURABLE_IO_LINES_GPIO: begin
          gpio_out_ff <= pwdata[NUM_CONFIGURABLE_IO_LINES-1:0];
          gpio_dir_ff <= pwdata[2*NUM_CONFIGURABLE_IO_LINES-1:NUM_CONFIGURABLE_IO_LINES];
        end
        ADDR_BB_DIR: bb_dir_ff <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        ADDR_CTRL: prdata = {26'h0000000, ctrl_ff};
        ADDR_BAUD: prdata = {15'h0000, div_frac_ff, div_int_ff};
        ADDR_RXTO: prdata = {24'h000000, rxto_ff};
        ADDR_INVERT: prdata = {24'h000000, invert_ff};
        ADDR_CONFIGURABLE_IO_LINES_FUNC: prdata = {16'h0000, configurable_io_lines_func_ff};
        ADDR_CONFIGURABLE_IO_LINES_GPIO: prdata = {24'h000000, gpio_dir_ff, gpio_out_ff};
        ADDR_RXDATA: prdata = {23'h000000, rx_valid_ff, rx_data_ff};
        ADDR_STATUS: prdata = {19'h00000, wake_ff, configurable_io_lines_sync_ff, line_log[LN_RI], line_log[LN_DCD],
                               line_log[LN_DSR], line_log[LN_CTS], overrun_ff, flush_ff, rx_valid_ff,
                               tx_busy_ff};
        ADDR_BB_IN: prdata = {24'h000000, line_sync_ff};
        ADDR_CHIP_ID: prdata = CHIP_ID;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // bit-rate ticks
  logic tx_restart;
  logic tx_tick;
  logic rx_restart;
  logic rx_tick;

  usu_baud_gen u_tx_baud (
    .clk(clk),
    .rst_n(rst_n),
    .restart(tx_restart),
    .half(1'b0),
    .div_int(div_int_ff),
    .div_frac(div_frac_ff),
    .tick(tx_tick)
  );

  usu_baud_gen u_rx_baud (
    .clk(clk),
    .rst_n(rst_n),
    .restart(rx_restart),
    .half(1'b1),
    .div_int(div_int_ff),
    .div_frac(div_frac_ff),
    .tick(rx_tick)
  );

  // ==========================================================
  // transmitter and bit-bang output port
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} usu_tx_state_t;
  usu_tx_state_t tx_state_ff;
  logic [7:0] tx_shift_ff;
  logic [2:0] tx_cnt_ff;
  logic tx_bit_ff;
  logic [7:0] bb_out_ff;
  logic [7:0] bb_pend_ff;
  logic tx_load;

  assign line_log = line_sync_ff ^ invert_ff;
  // writes while busy are dropped; software polls the busy flag
  assign tx_load = wr_en && paddr == ADDR_TXDATA && !tx_busy_ff;
  assign tx_restart = tx_load;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_ff <= TX_IDLE;
      tx_shift_ff <= 8'h00;
      tx_cnt_ff <= 3'h0;
      tx_bit_ff <= 1'b1;
      tx_busy_ff <= 1'b0;
      bb_out_ff <= 8'h00;
      bb_pend_ff <= 8'h00;
    end else if (soft_rst) begin
      tx_state_ff <= TX_IDLE;
      tx_bit_ff <= 1'b1;
      tx_busy_ff <= 1'b0;
      bb_out_ff <= 8'h00;
    end else if (ctrl_ff.bitbang_en) begin
      tx_state_ff <= TX_IDLE;
      tx_bit_ff <= 1'b1;
      if (tx_load) begin
        bb_pend_ff <= pwdata[7:0];
        tx_busy_ff <= 1'b1;
      end else if (tx_busy_ff && tx_tick) begin
        bb_out_ff <= bb_pend_ff;
        tx_busy_ff <= 1'b0;
      end
    end else begin
      unique case (tx_state_ff)
        TX_IDLE: begin
          tx_bit_ff <= 1'b1;
          if (tx_load) begin
            tx_shift_ff <= pwdata[7:0];
            tx_busy_ff <= 1'b1;
            tx_bit_ff <= 1'b0;
            tx_state_ff <= TX_START;
          end
        end
        TX_START: if (tx_tick) begin
          tx_bit_ff <= tx_shift_ff[0];
          tx_cnt_ff <= 3'h0;
          tx_state_ff <= TX_DATA;
        end
        TX_DATA: if (tx_tick) begin
          if (tx_cnt_ff == 3'h7) begin
            tx_bit_ff <= 1'b1;
            tx_state_ff <= TX_STOP;
          end else begin
            tx_bit_ff <= tx_shift_ff[3'(tx_cnt_ff + 3'h1)];
            tx_cnt_ff <= tx_cnt_ff + 3'h1;
          end
        end
        TX_STOP: if (tx_tick) begin
          tx_busy_ff <= 1'b0;
          tx_state_ff <= TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // receiver
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usu_rx_state_t;
  usu_rx_state_t rx_state_ff;
  logic [7:0] rx_shift_ff;
  logic [2:0] rx_cnt_ff;
  logic rx_done;
  logic rx_rd;
  logic flush_evt;
  logic st_wr;

  assign rx_restart = rx_state_ff == RX_IDLE && !line_log[LN_RXD] && !ctrl_ff.bitbang_en;
  assign rx_done = rx_state_ff == RX_STOP && rx_tick && line_log[LN_RXD];
  assign rx_rd = rd_en && paddr == ADDR_RXDATA;
  assign st_wr = wr_en && paddr == ADDR_STATUS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_ff <= RX_IDLE;
      rx_shift_ff <= 8'h00;
      rx_cnt_ff <= 3'h0;
    end else if (soft_rst || ctrl_ff.bitbang_en) begin
      rx_state_ff <= RX_IDLE;
    end else begin
      unique case (rx_state_ff)
        RX_IDLE: if (rx_restart) rx_state_ff <= RX_START;
        // a start bit that is gone at mid-bit is taken as a glitch
        RX_START: if (rx_tick) begin
          rx_state_ff <= line_log[LN_RXD] ? RX_IDLE : RX_DATA;
          rx_cnt_ff <= 3'h0;
        end
        RX_DATA: if (rx_tick) begin
          rx_shift_ff <= {line_log[LN_RXD], rx_shift_ff[7:1]};
          rx_cnt_ff <= rx_cnt_ff + 3'h1;
          if (rx_cnt_ff == 3'h7) rx_state_ff <= RX_STOP;
        end
        RX_STOP: if (rx_tick) rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  // new data wins over a read in the same cycle; sticky flags set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
      overrun_ff <= 1'b0;
      flush_ff <= 1'b0;
    end else if (soft_rst) begin
      rx_valid_ff <= 1'b0;
      overrun_ff <= 1'b0;
      flush_ff <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_data_ff <= rx_shift_ff;
        rx_valid_ff <= 1'b1;
      end else if (rx_rd) begin
        rx_valid_ff <= 1'b0;
      end
      overrun_ff <= (rx_done && rx_valid_ff && !rx_rd) || (overrun_ff && !(st_wr && pwdata[ST_OVERRUN]));
      flush_ff <= flush_evt || (flush_ff && !(st_wr && pwdata[ST_FLUSH]));
    end
  end

  // ==========================================================
  // millisecond base and receive flush timeout
  logic [$clog2(MS_CYC)-1:0] ms_cnt_ff;
  logic ms_tick;
  logic [7:0] idle_ms_ff;

  assign ms_tick = ms_cnt_ff == ($clog2(MS_CYC))'(MS_CYC - 1);
  assign flush_evt = rx_valid_ff && ms_tick && idle_ms_ff == rxto_ff - 8'h01 && !rx_done;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_ff <= '0;
      idle_ms_ff <= 8'h00;
      rx_flush <= 1'b0;
    end else begin
      ms_cnt_ff <= ms_tick ? '0 : ms_cnt_ff + 1'b1;
      rx_flush <= flush_evt;
      if (rx_done || !rx_valid_ff || flush_evt) begin
        idle_ms_ff <= 8'h00;
      end else if (ms_tick) begin
        idle_ms_ff <= idle_ms_ff + 8'h01;
      end
    end
  end

  // ==========================================================
  // ring indicator wakeup and power switch
  logic [$clog2(WAKE_CYC+1)-1:0] ri_cnt_ff;
  logic ri_fire;

  assign ri_fire = ri_cnt_ff == ($clog2(WAKE_CYC+1))'(WAKE_CYC);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ri_cnt_ff <= '0;
      usb_resume_req <= 1'b0;
      wake_ff <= 1'b0;
      power_switch_enable_n <= 1'b1;
    end else begin
      // counting stops at the limit so a long low requests resume once
      if (!(ctrl_ff.wake_en && usb_suspend && line_log[LN_RI] == 1'b0) || soft_rst) begin
        ri_cnt_ff <= '0;
      end else if (!ri_fire) begin
        ri_cnt_ff <= ri_cnt_ff + 1'b1;
      end
      usb_resume_req <= ri_cnt_ff == ($clog2(WAKE_CYC+1))'(WAKE_CYC - 1);
      wake_ff <= usb_resume_req || (wake_ff && !(st_wr && pwdata[ST_WAKE]));
      power_switch_enable_n <= !(usb_configured && !usb_suspend);
    end
  end
  assign uart_bleed_pulldown = ctrl_ff.bleed_en && power_switch_enable_n;

  // ==========================================================
  // uart pin drive
  logic [7:0] uart_log_out;

  always_comb begin
    uart_log_out = 8'h00;
    uart_log_out[LN_TXD] = tx_bit_ff;
    uart_log_out[LN_RTS] = !ctrl_ff.rts;
    uart_log_out[LN_DTR] = !ctrl_ff.dtr;
  end

  always_comb begin
    if (ctrl_ff.bitbang_en) begin
      uart_line_out = bb_out_ff;
      uart_line_oe_n = ~bb_dir_ff;
    end else begin
      uart_line_out = (uart_log_out ^ invert_ff) & UART_OUT_MASK;
      uart_line_oe_n = ~UART_OUT_MASK;
    end
  end

  // ==========================================================
  // configurable lines
  logic [6:0] ck_acc_ff;
  logic [3:0] ck_div_ff;
  logic [$clog2(ACT_PULSE_CYCLES)-1:0] tx_act_ff;
  logic [$clog2(ACT_PULSE_CYCLES)-1:0] rx_act_ff;
  logic tx_act_on;
  logic rx_act_on;

  // jittered clock outputs: the system clock is no multiple of 48 mhz
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_acc_ff <= 7'h00;
      ck_div_ff <= 4'h0;
      tx_act_ff <= '0;
      rx_act_ff <= '0;
    end else begin
      // one extra bit so the sum cannot wrap before the compare
      if ({1'b0, ck_acc_ff} + 8'(CLKOUT_STEP) >= 8'(CLKOUT_MOD)) begin
        ck_acc_ff <= 7'(ck_acc_ff + 7'(CLKOUT_STEP) - 7'(CLKOUT_MOD));
        ck_div_ff <= ck_div_ff + 4'h1;
      end else begin
        ck_acc_ff <= ck_acc_ff + 7'(CLKOUT_STEP);
      end
      tx_act_ff <= tx_load ? '1 : (tx_act_on ? tx_act_ff - 1'b1 : tx_act_ff);
      rx_act_ff <= rx_done ? '1 : (rx_act_on ? rx_act_ff - 1'b1 : rx_act_ff);
    end
  end
  assign tx_act_on = tx_act_ff != '0;
  assign rx_act_on = rx_act_ff != '0;

  always_comb begin
    for (int i = 0; i < NUM_CONFIGURABLE_IO_LINES; i++) begin
      configurable_io_lines_oe_n[i] = 1'b0;
      unique case (usu_configurable_io_lines_func_t'(configurable_io_lines_func_ff[4*i +: 4]))
        CB_TX_DRIVER_ENABLE: configurable_io_lines_out[i] = tx_busy_ff && !ctrl_ff.bitbang_en;
        CB_POWER_SWITCH_ENABLE: configurable_io_lines_out[i] = power_switch_enable_n;
        CB_TX_ACT: configurable_io_lines_out[i] = !tx_act_on;
        CB_RX_ACT: configurable_io_lines_out[i] = !rx_act_on;
        CB_TXRX_ACT: configurable_io_lines_out[i] = !(tx_act_on || rx_act_on);
        CB_SUSPEND: configurable_io_lines_out[i] = !usb_suspend;
        CB_CLOCK_OUT_48M: configurable_io_lines_out[i] = ck_div_ff[0];
        CB_CLOCK_OUT_24M: configurable_io_lines_out[i] = ck_div_ff[1];
        CB_CLOCK_OUT_12M: configurable_io_lines_out[i] = ck_div_ff[2];
        CB_CLOCK_OUT_6M: configurable_io_lines_out[i] = ck_div_ff[3];
        CB_GPIO: begin
          configurable_io_lines_out[i] = ctrl_ff.configurable_io_lines_bitbang_en && gpio_out_ff[i];
          configurable_io_lines_oe_n[i] = !(ctrl_ff.configurable_io_lines_bitbang_en && gpio_dir_ff[i]);
        end
        default: begin
          configurable_io_lines_out[i] = 1'b0;
          configurable_io_lines_oe_n[i] = 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: testbench/usu_uart_top_chk.sv
// port assertions for the uart line option block
`timescale 1ns/1ps
`default_nettype none
module usu_uart_top_chk(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic uart_bleed_pulldown,
  input wire logic usb_configured,
  input wire logic usb_suspend,
  input wire logic usb_resume_req,
  input wire logic rx_flush,
  input wire logic power_switch_enable_n
);
  // =====
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  apb_ready_a: assert property (psel && penable |-> pready) else $error("no ready");
  apb_err_a: assert property (pslverr |-> psel && penable) else $error("stray error");
  rd_idle_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0) else $error("stray data");
  bleed_off_a: assert property (uart_bleed_pulldown |-> power_switch_enable_n) else $error("bleed on power");
  pwr_state_a: assert property ($past(rst_n) |-> power_switch_enable_n == !$past(usb_configured && !usb_suspend))
    else $error("power switch wrong");
  resume_one_a: assert property (usb_resume_req |=> !usb_resume_req) else $error("resume too long");
  resume_why_a: assert property (usb_resume_req |-> $past(usb_suspend, 2)) else $error("resume awake");
  flush_one_a: assert property (rx_flush |=> !rx_flush [*8]) else $error("flush repeats");
  cover property (rx_flush);
  cover property (usb_resume_req);
  cover property (uart_bleed_pulldown);
endmodule
`default_nettype wire

// file: testbench/usu_far_end.sv
// far-end serial logic: echoes transmit data and drives the modem inputs
`timescale 1ns/1ps
`default_nettype none
module usu_far_end(
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic ring_n,
  output logic [7:0] pin_in
);
  logic [7:0] far;
  // cts, dsr, dcd stay deasserted high; rxd echoes txd
  assign far = {ring_n, 5'h1f, pin_out[0], 1'b1};
  assign pin_in = (far & pin_oe_n) | (pin_out & ~pin_oe_n);
endmodule
`default_nettype wire

// file: testbench/usb_serial_uart_line_options_bench.sv
// self-checking bench for the uart line option block
`timescale 1ns/1ps
`default_nettype none
module usb_serial_uart_line_options_bench;
  import usu_pkg::*;
  logic clk = 0, rst_n = 0, ext_reset_n = 1, psel = 0, penable = 0, pwrite = 0;
  logic usb_configured = 0, usb_suspend = 0, ring_n = 1;
  logic pready, pslverr, usb_resume_req, rx_flush, power_switch_enable_n, uart_bleed_pulldown;
  logic [7:0] paddr = 8'h0;
  logic [7:0] line_in, line_out, line_oe_n;
  logic [3:0] cb_out;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] lfsr = 16'h3a1a;
  logic [31:0] exp_q[$];
  logic [7:0] ra[6] = '{ADDR_CTRL, ADDR_BAUD, ADDR_RXTO, ADDR_CONFIGURABLE_IO_LINES_FUNC, ADDR_CHIP_ID, 8'h30};
  logic [31:0] rv[6] = '{32'h0, 32'h2710, 32'h10, {16'h0, CONFIGURABLE_IO_LINES_FUNC_RST}, 32'h1234_abcd, 32'h0};
  int error_cnt = 0, cmp_count = 0, fl_cnt = 0, rs_cnt = 0;
  // =====
  // design and far end
  usu_uart_top #(.MS_CYC(50), .WAKE_CYC(200), .CHIP_ID(32'h1234_abcd)) usu_uart_top_inst (.*,
    .uart_line_in(line_in), .uart_line_out(line_out), .uart_line_oe_n(line_oe_n),
    .configurable_io_lines_in(cb_out), .configurable_io_lines_out(cb_out), .configurable_io_lines_oe_n());
  usu_far_end usu_far_end_inst (.pin_out(line_out), .pin_oe_n(line_oe_n), .ring_n(ring_n), .pin_in(line_in));
  // =====
  // helpers
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // reads note their expectation; the monitor below compares at the access edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (!pready);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) check("prdata", prdata, exp_q.pop_front());
    if (psel && penable && pready) check("pslverr", pslverr, {31'h0, paddr == 8'h30});
    fl_cnt <= fl_cnt + int'(rx_flush);
    rs_cnt <= rs_cnt + int'(usb_resume_req);
  end
  initial forever #5 clk = ~clk;
  initial begin
    #200us;
    error_cnt++;
    end_of_test();
  end
  // =====
  // tests
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    check("txd idle", line_out[0], 32'h1);
    foreach (ra[i]) bus(0, ra[i], rv[i]);
    bus(1, ADDR_RXTO, 32'h0);
    bus(0, ADDR_RXTO, 32'h1);
    bus(1, ADDR_RXTO, 32'hff);
    bus(0, ADDR_RXTO, 32'hff);
    bus(1, ADDR_RXTO, 32'h1);
    // the last pass leaves the slowest fractional divisor in place for the loopback
    for (int f = 0; f < 8; f++) begin
      bus(1, ADDR_BAUD, {15'h0, f[2:0], 14'h2});
      bus(0, ADDR_BAUD, {15'h0, f[2:0], 14'h2});
    end
    $display("setup tests done");
    lfsr = nxt(lfsr);
    bus(1, ADDR_TXDATA, {24'h0, lfsr[7:0]});
    for (int i = 0; i < 3000 && fl_cnt == 0; i++) @(posedge clk);
    check("flush", fl_cnt, 32'h1);
    bus(0, ADDR_RXDATA, {23'h0, 1'b1, lfsr[7:0]});
    $display("loopback done");
    bus(1, ADDR_CTRL, 32'h4);
    #1 check("bleed", uart_bleed_pulldown, 32'h1);
    usb_configured <= 1;
    repeat (3) @(posedge clk);
    #1 check("bleed off", uart_bleed_pulldown, 32'h0);
    bus(1, ADDR_CTRL, 32'h8);
    usb_suspend <= 1;
    // a low too short to wake, a gap, then a low well past the limit
    ring_n <= 0;
    repeat (100) @(posedge clk);
    ring_n <= 1;
    repeat (10) @(posedge clk);
    ring_n <= 0;
    repeat (300) @(posedge clk);
    ring_n <= 1;
    repeat (2) @(posedge clk);
    check("resume", rs_cnt, 32'h1);
    $display("power tests done");
    bus(1, ADDR_INVERT, 32'h1);
    #1 check("txd inverted", line_out[0], 32'h0);
    @(posedge clk) ext_reset_n <= 0;
    repeat (2) @(posedge clk) ext_reset_n <= 1;
    repeat (4) @(posedge clk);
    bus(0, ADDR_INVERT, 32'h0);
    bus(0, ADDR_RXTO, 32'h10);
    $display("reset tests done");
    end_of_test();
  end
endmodule
bind usu_uart_top usu_uart_top_chk usu_uart_top_chk_inst (.*);
`default_nettype wire
